// File: pkg/flash_map_pkg.sv
// Purpose: Shared constants and carriers for the flash map and protect decoder
// Assumes: APB register access, byte-wide registers in the low data lane
// Notes: Register byte address is base plus 400 hex plus four times the register index
package flash_map_pkg;

  // ************************************************************
  // Register window
  // ************************************************************
  localparam logic [25:0] REG_WIN_TAG = 26'h0000010;
  localparam int REG_COUNT = 16;
  localparam logic [3:0] IDX_CLKDIV = 4'h0;
  localparam logic [3:0] IDX_SECURITY = 4'h1;
  localparam logic [3:0] IDX_TESTMODE = 4'h2;
  localparam logic [3:0] IDX_CONFIG = 4'h3;
  localparam logic [3:0] IDX_PROT = 4'h4;
  localparam logic [3:0] IDX_STATUS = 4'h5;
  localparam logic [3:0] IDX_COMMAND = 4'h6;
  localparam logic [3:0] IDX_RSVD = 4'h7;
  localparam logic [3:0] IDX_ADDR_HI = 4'h8;
  localparam logic [3:0] IDX_ADDR_LO = 4'h9;
  localparam logic [3:0] IDX_DATA_HI = 4'hA;
  localparam logic [3:0] IDX_DATA_LO = 4'hB;
  localparam logic [3:0] IDX_UNDEF_LO = 4'hC;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int CLKDIV_LOADED = 7;
  localparam logic [7:0] CLKDIV_WMASK = 8'h7F;
  localparam int CFG_BANK = 0;
  localparam logic [7:0] CFG_WMASK = 8'hE1;
  localparam int PROT_OPEN = 7;
  localparam int PROT_HDIS = 5;
  localparam int PROT_HS_LSB = 3;
  localparam int PROT_LDIS = 2;
  localparam int PROT_LS_LSB = 0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ************************************************************
  // CPU map
  // ************************************************************
  localparam logic [1:0] WIN_FIX_LO = 2'h1;
  localparam logic [1:0] WIN_PAGED = 2'h2;
  localparam logic [1:0] WIN_FIX_HI = 2'h3;
  localparam logic [7:0] PAGE_FIX_LO = 8'h3E;
  localparam logic [7:0] PAGE_FIX_HI = 8'h3F;
  localparam logic [4:0] PAGE_TAG = 5'h07;
  localparam logic [16:0] LOW_START = 17'h08000;
  localparam logic [16:0] LOW_MIN = 17'h00200;
  localparam logic [16:0] HIGH_END_P1 = 17'h10000;
  localparam logic [16:0] HIGH_MIN = 17'h00800;
  localparam logic [11:0] OPT_FIELD_TAG = 12'hFF0;
  localparam logic [15:0] PROT_BYTE_BLK1_ADDR = 16'hFF0C;
  localparam logic [15:0] PROT_BYTE_BLK0_ADDR = 16'hFF0D;
  localparam logic [15:0] OPTION_BYTE_ADDR = 16'hFF0F;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
  } cpu_req_s;

  typedef struct packed {
    logic hit;
    logic block;
    logic [7:0] page;
    logic [15:0] rel;
    logic opt_field;
    logic viol;
  } map_s;

  typedef enum logic {ST_LOAD, ST_RUN} load_state_e;

endpackage

// File: src/flash_map_bank_protect_decode.sv
// Purpose: Flash page map, protection decode and banked register file
// Assumes: Protection and option bytes are presented by the array at reset
// Notes on behaviour
// [RQ1] Sixteen byte registers at base plus 100-10F
// [RQ2] Offsets 04-0B banked, chosen by bank bit; the code banks only 04-06, and 07-0B read zero in both banks
// [RQ3] Divider, security, test mode, configuration at 00-03
// [RQ4] Banked protection, status, command at 04-06
// [RQ5] Factory test registers 07-0B read only
// [RQ6] Decoded address is base plus offset
// [RQ7] Middle window follows external page select
// [RQ8] Pages 38-3F map onto two blocks
// [RQ9] Fixed windows map pages 3E and 3F
// [RQ10] Sixteen byte options field in block 0
// [RQ11] Options field layout at FF00-FF0F
// [RQ12] Closed block refuses all program and erase
// [RQ13] Lower and higher protected areas per block
// [RQ14] Block 0 lower range from 4000, four sizes
// [RQ15] Block 0 higher range ends FFFF, four sizes
// [RQ16] Block 1 ranges in pages 3A and 3B
// [RQ17] No off-chip ports, internal bus only
// [RQ18] Software keeps boot code in high range
// [RQ19] Bank 0 selected after reset
// [RQ20] Protection loaded from option bytes at reset
// [RQ21] Offsets 0C-0F read zero, writes ignored
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Every port stays inside the chip; no pad connects here [RQ17]
module flash_map_bank_protect_decode (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [31:0] base_addr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire flash_map_pkg::cpu_req_s cpu_req,
  input wire logic [7:0] memory_page_select,
  output flash_map_pkg::map_s map_out,
  input wire logic [7:0] prot_byte_blk0,
  input wire logic [7:0] prot_byte_blk1,
  input wire logic [7:0] option_byte,
  output logic [1:0] protection_open_bit,
  output logic bank_select_bit
);
  import flash_map_pkg::*;

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [7:0] clock_divider_r;
  logic [7:0] security_state_r;
  logic [7:0] module_configuration_r;
  logic [7:0] sector_protection_r [2];
  logic [7:0] operation_status_r [2];
  logic [7:0] operation_command_r [2];
  logic [31:0] prdata_r;
  map_s map_r;
  load_state_e state_r;

  // ************************************************************
  // APB decode
  // ************************************************************
  logic [31:0] reg_off;
  logic win_hit;
  logic [3:0] idx;
  logic wr_en;
  logic rd_setup;
  logic bank;
  logic [7:0] wbyte;
  logic [7:0] rd_mux;

  // Base relative word index
  assign reg_off = paddr - base_addr; // [RQ6]
  assign win_hit = reg_off[31:6] == REG_WIN_TAG; // [RQ1]
  assign idx = reg_off[5:2];
  assign wbyte = pwdata[7:0];
  assign bank = module_configuration_r[CFG_BANK];
  assign wr_en = psel && penable && pwrite && win_hit && (state_r == ST_RUN);
  assign rd_setup = psel && !penable && !pwrite;

  // Always ready, never errors
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_r;
  assign map_out = map_r;
  assign bank_select_bit = bank;

  // Reset load sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_LOAD;
    end else begin
      case (state_r)
        ST_LOAD: state_r <= ST_RUN;
        ST_RUN: state_r <= ST_RUN;
        default: state_r <= ST_LOAD;
      endcase
    end
  end

  // Read mux of the selected bank
  always_comb begin
    rd_mux = REG_RESET;
    if (win_hit) begin
      case (idx)
        IDX_CLKDIV: rd_mux = clock_divider_r; // [RQ3]
        IDX_SECURITY: rd_mux = security_state_r;
        IDX_TESTMODE: rd_mux = REG_RESET;
        IDX_CONFIG: rd_mux = module_configuration_r;
        IDX_PROT: rd_mux = sector_protection_r[bank]; // [RQ2] [RQ4]
        IDX_STATUS: rd_mux = operation_status_r[bank];
        IDX_COMMAND: rd_mux = operation_command_r[bank];
        IDX_RSVD, IDX_ADDR_HI, IDX_ADDR_LO, IDX_DATA_HI, IDX_DATA_LO: rd_mux = REG_RESET; // [RQ5]
        default: rd_mux = REG_RESET; // [RQ21]
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_r <= {24'h000000, rd_mux};
    end
  end

  // ************************************************************
  // Unbanked registers
  // ************************************************************

  // Divider: low bits write once, top bit marks loaded
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clock_divider_r <= REG_RESET;
    end else if (wr_en && idx == IDX_CLKDIV && !clock_divider_r[CLKDIV_LOADED]) begin
      clock_divider_r <= (wbyte & CLKDIV_WMASK) | ~CLKDIV_WMASK; // [RQ3]
    end
  end

  // Security taken from the options byte after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      security_state_r <= REG_RESET;
    end else if (state_r == ST_LOAD) begin
      security_state_r <= option_byte; // [RQ11]
    end
  end

  // Configuration with bank select
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      module_configuration_r <= REG_RESET; // [RQ19]
    end else if (wr_en && idx == IDX_CONFIG) begin
      module_configuration_r <= wbyte & CFG_WMASK; // [RQ3]
    end
  end

  // ************************************************************
  // Banked registers
  // ************************************************************

  // Protection: load at reset, then only toward protected
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sector_protection_r[0] <= REG_RESET;
      sector_protection_r[1] <= REG_RESET;
    end else if (state_r == ST_LOAD) begin
      sector_protection_r[0] <= prot_byte_blk0; // [RQ20]
      sector_protection_r[1] <= prot_byte_blk1;
    end else if (wr_en && idx == IDX_PROT) begin
      sector_protection_r[bank] <= prot_wr(sector_protection_r[bank], wbyte); // [RQ2]
    end
  end

  // Next protection value under the lock rules
  function automatic logic [7:0] prot_wr(input logic [7:0] cur, input logic [7:0] wv);
    logic [7:0] n;
    n = cur;
    n[PROT_OPEN] = cur[PROT_OPEN] & wv[PROT_OPEN];
    n[PROT_HDIS] = cur[PROT_HDIS] & wv[PROT_HDIS];
    n[PROT_LDIS] = cur[PROT_LDIS] & wv[PROT_LDIS];
    if (cur[PROT_HDIS]) begin
      n[PROT_HS_LSB+:2] = wv[PROT_HS_LSB+:2];
    end
    if (cur[PROT_LDIS]) begin
      n[PROT_LS_LSB+:2] = wv[PROT_LS_LSB+:2];
    end
    return n;
  endfunction

  // Status and command copies per block
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      operation_status_r[0] <= REG_RESET;
      operation_status_r[1] <= REG_RESET;
      operation_command_r[0] <= REG_RESET;
      operation_command_r[1] <= REG_RESET;
    end else if (wr_en) begin
      if (idx == IDX_STATUS) begin
        operation_status_r[bank] <= wbyte; // [RQ4]
      end
      if (idx == IDX_COMMAND) begin
        operation_command_r[bank] <= wbyte; // [RQ4]
      end
    end
  end

  // Open bits per block
  assign protection_open_bit[0] = sector_protection_r[0][PROT_OPEN];
  assign protection_open_bit[1] = sector_protection_r[1][PROT_OPEN];

  // ************************************************************
  // CPU address map and protection
  // ************************************************************
  logic [7:0] page;
  logic page_ok;
  logic blk;
  logic [15:0] rel;
  logic [7:0] pr;
  logic [16:0] low_end;
  logic [16:0] high_start;
  logic in_low;
  logic in_high;
  logic viol;

  // Window to physical page
  always_comb begin
    case (cpu_req.addr[15:14])
      WIN_FIX_LO: page = PAGE_FIX_LO; // [RQ9]
      WIN_PAGED: page = memory_page_select; // [RQ7]
      WIN_FIX_HI: page = PAGE_FIX_HI; // [RQ9]
      default: page = 8'h00;
    endcase
  end

  // Page to block and block relative address
  assign page_ok = (cpu_req.addr[15:14] != 2'h0) && (page[7:3] == PAGE_TAG); // [RQ8]
  assign blk = ~page[2]; // [RQ8]
  assign rel = {page[1:0], cpu_req.addr[13:0]};

  // Range sizes double with each size code
  assign pr = sector_protection_r[blk];
  assign low_end = LOW_START + (LOW_MIN << pr[PROT_LS_LSB+:2]); // [RQ14] [RQ16]
  assign high_start = HIGH_END_P1 - (HIGH_MIN << pr[PROT_HS_LSB+:2]); // [RQ15] [RQ16]
  assign in_low = ({1'b0, rel} >= LOW_START) && ({1'b0, rel} < low_end); // [RQ13]
  assign in_high = {1'b0, rel} >= high_start; // [RQ13]

  // Program or erase refused when closed or in an active range
  always_comb begin
    viol = 1'b0;
    if (cpu_req.valid && cpu_req.write && page_ok) begin
      if (!pr[PROT_OPEN]) begin
        viol = 1'b1; // [RQ12]
      end else if ((in_low && !pr[PROT_LDIS]) || (in_high && !pr[PROT_HDIS])) begin
        viol = 1'b1; // [RQ13]
      end
    end
  end

  // Registered map result
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      map_r <= '0;
    end else begin
      map_r.hit <= cpu_req.valid && page_ok;
      map_r.block <= blk;
      map_r.page <= page;
      map_r.rel <= rel;
      map_r.opt_field <= cpu_req.valid && page_ok && !blk && rel[15:4] == OPT_FIELD_TAG; // [RQ10] [RQ11]
      map_r.viol <= viol;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  // Steps shared by the checks
  sequence s_load;
    state_r == ST_LOAD;
  endsequence

  sequence s_closed_write;
    cpu_req.valid && cpu_req.write && page_ok && !pr[PROT_OPEN];
  endsequence

  sequence s_undef_read;
    rd_setup && win_hit && idx >= IDX_UNDEF_LO;
  endsequence

  // Reset and load behaviour
  AST_BANK_RESET: assert property (@(posedge clock) disable iff (!rst_n) // [RQ19]
    s_load |-> !bank_select_bit)
    else $error("bank not zero after reset");

  AST_PROT_LOAD: assert property (@(posedge clock) disable iff (!rst_n) // [RQ20]
    s_load |=> sector_protection_r[0] == $past(prot_byte_blk0) && sector_protection_r[1] == $past(prot_byte_blk1))
    else $error("protection not loaded");

  AST_FIX_LO: assert property (@(posedge clock) disable iff (!rst_n) // [RQ9]
    cpu_req.valid && cpu_req.addr[15:14] == WIN_FIX_LO |=> map_out.hit && map_out.page == PAGE_FIX_LO && !map_out.block)
    else $error("low fixed window misrouted");

  AST_FIX_HI: assert property (@(posedge clock) disable iff (!rst_n) // [RQ9]
    cpu_req.valid && cpu_req.addr[15:14] == WIN_FIX_HI |=> map_out.page == PAGE_FIX_HI && map_out.rel[15:14] == 2'h3)
    else $error("high fixed window misrouted");

  AST_PAGED: assert property (@(posedge clock) disable iff (!rst_n) // [RQ7]
    cpu_req.valid && cpu_req.addr[15:14] == WIN_PAGED |=> map_out.page == $past(memory_page_select))
    else $error("paged window ignores page select");

  AST_BLOCK: assert property (@(posedge clock) disable iff (!rst_n) // [RQ8]
    map_out.hit |-> map_out.block == !map_out.page[2] && map_out.rel[15:14] == map_out.page[1:0])
    else $error("page to block decode wrong");

  AST_CLOSED: assert property (@(posedge clock) disable iff (!rst_n) // [RQ12]
    s_closed_write |=> map_out.viol)
    else $error("closed block accepted write");

  AST_UNDEF: assert property (@(posedge clock) disable iff (!rst_n) // [RQ21]
    s_undef_read |=> prdata == 32'h00000000)
    else $error("undefined offset read nonzero");

  // Bank 0 write leaves the block 1 copy alone
  AST_BANK_ROUTE: assert property (@(posedge clock) disable iff (!rst_n) // [RQ2]
    wr_en && idx == IDX_STATUS && !bank |=> operation_status_r[0] == $past(wbyte)
      && $stable(operation_status_r[1]))
    else $error("banked write misrouted");

  // Bank 1 write leaves the block 0 copy alone
  AST_BANK_ROUTE1: assert property (@(posedge clock) disable iff (!rst_n) // [RQ2]
    wr_en && idx == IDX_STATUS && bank |=> operation_status_r[1] == $past(wbyte)
      && $stable(operation_status_r[0]))
    else $error("banked write misrouted to block 0 copy");

  AST_LOW_RANGE: assert property (@(posedge clock) disable iff (!rst_n) // [RQ14]
    cpu_req.valid && cpu_req.write && page_ok && pr[PROT_OPEN] && !pr[PROT_LDIS]
      && rel == LOW_START[15:0] |=> map_out.viol)
    else $error("lower range start not protected");

  // Higher range always covers the top of the block while enabled
  AST_HIGH_RANGE: assert property (@(posedge clock) disable iff (!rst_n) // [RQ15]
    cpu_req.valid && cpu_req.write && page_ok && pr[PROT_OPEN] && !pr[PROT_HDIS]
      && {1'b0, rel} >= HIGH_END_P1 - HIGH_MIN |=> map_out.viol)
    else $error("higher range top not protected");

  // Accesses off the flash pages neither hit nor violate
  AST_OUTSIDE: assert property (@(posedge clock) disable iff (!rst_n) // [RQ8]
    cpu_req.valid && !page_ok |=> !map_out.hit && !map_out.viol)
    else $error("access outside flash pages decoded");

  // Reads never raise a violation
  AST_READ_FREE: assert property (@(posedge clock) disable iff (!rst_n) // [RQ12]
    !(cpu_req.valid && cpu_req.write) |=> !map_out.viol)
    else $error("violation flagged without a write");

  // Divider frozen once loaded
  AST_DIV_ONCE: assert property (@(posedge clock) disable iff (!rst_n) // [RQ3]
    clock_divider_r[CLKDIV_LOADED] |=> $stable(clock_divider_r))
    else $error("divider changed after first write");

  // Closed block 0 stays closed until the next reset
  AST_STAY_CLOSED: assert property (@(posedge clock) disable iff (!rst_n) // [RQ12]
    state_r == ST_RUN && !protection_open_bit[0] |=> !protection_open_bit[0])
    else $error("closed block reopened");

  // Security byte only changes in the load cycle
  AST_SEC_RO: assert property (@(posedge clock) disable iff (!rst_n) // [RQ3]
    state_r == ST_RUN |=> $stable(security_state_r))
    else $error("security register written");

endmodule

`default_nettype wire

// File: test/cpu_host_model.sv
// Purpose: Host CPU side with its page register, making flash map accesses
// Assumes: Map answer registered one clock after the request
// Notes: Idle address is inverted so a stale request never matches
`timescale 1ns/1ps
`default_nettype none

module cpu_host_model (
  input wire logic clock,
  output flash_map_pkg::cpu_req_s cpu_req,
  output logic [7:0] memory_page_select,
  input wire flash_map_pkg::map_s map_out
);
  import flash_map_pkg::*;

  // ************************************************
  // Bus activity
  // ************************************************
  // Quiet bus at start
  initial begin
    cpu_req = '0;
    memory_page_select = 8'h00;
  end

  // One access, answer taken once the map has registered it
  task automatic cycle(input logic [7:0] pg, input logic [15:0] a, input logic w, output map_s m);
    @(posedge clock);
    memory_page_select <= pg; // Page held between accesses
    cpu_req <= '{valid: 1'b1, write: w, addr: a};
    @(posedge clock);
    cpu_req.valid <= 1'b0;
    cpu_req.addr <= ~a; // Stale address never repeated
    #1;
    m = map_out;
  endtask
endmodule

`default_nettype wire

// File: test/flash_map_bank_protect_decode_tb.sv
// Purpose: Self-checking bench for flash map, protection and registers
// Assumes: APB slave always ready, map answer one clock late
// Notes: Two resets with different protection bytes
`timescale 1ns/1ps
`default_nettype none

module flash_map_bank_protect_decode_tb;
  import flash_map_pkg::*;

  // ************************************************
  // Signals and instances
  // ************************************************
  localparam logic [31:0] BASE = 32'h0002_0000;
  localparam logic [15:0] FX [9] = '{16'h0000, 16'h3FFF, 16'h4000, 16'h41FF, 16'h4200,
                                     16'h7FFF, 16'hF7FF, 16'hF800, 16'hFF0D};
  localparam logic [15:0] PA [9] = '{16'h8000, 16'h8000, 16'h81FF, 16'h8200, 16'h8FFF,
                                     16'h9000, 16'hB7FF, 16'hB800, 16'hBFFF};
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, bank_select_bit;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic se;
  logic [7:0] pb0, pb1, opt, ep0, ep1, memory_page_select;
  logic [1:0] protection_open_bit;
  cpu_req_s cpu_req;
  map_s map_out, m;
  int err_count, checks_done;

  flash_map_bank_protect_decode dut (.clock(clock), .rst_n(rst_n), .base_addr(BASE), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req), .memory_page_select(memory_page_select),
    .map_out(map_out), .prot_byte_blk0(pb0), .prot_byte_blk1(pb1), .option_byte(opt),
    .protection_open_bit(protection_open_bit), .bank_select_bit(bank_select_bit));
  cpu_host_model host (.clock(clock), .cpu_req(cpu_req), .memory_page_select(memory_page_select),
    .map_out(map_out));

  // Free running clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ************************************************
  // Shared tasks
  // ************************************************
  task conclude;
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task chk_map(input map_s got, input map_s exp);
    checks_done++;
    if ((exp.hit && got !== exp) || {got.hit, got.viol} !== {exp.hit, exp.viol}) begin
      err_count++;
      $display("[FAIL] %0t map %h expected %h", $time, got, exp);
    end
  endtask

  // Expected map answer from window, page and protection byte
  function automatic map_s ref_map(input logic [7:0] ps, input logic [15:0] a, input logic w);
    map_s r;
    logic [7:0] pb;
    logic [16:0] x;
    r = '0;
    r.page = (a[15:14] == 2'h1) ? 8'h3E : (a[15:14] == 2'h3) ? 8'h3F : ps;
    if (a[15:14] == 2'h0 || r.page[7:3] != 5'h07) return '0;
    r.hit = 1'b1;
    r.block = ~r.page[2];
    r.rel = {r.page[1:0], a[13:0]};
    r.opt_field = !r.block && r.rel[15:4] == 12'hFF0;
    pb = r.block ? ep1 : ep0;
    x = {1'b0, r.rel};
    r.viol = w && (!pb[7] || (!pb[2] && x >= 17'h08000 && x < 17'h08000 + (17'h00200 << pb[1:0]))
             || (!pb[5] && x >= 17'h10000 - (17'h00800 << pb[4:3])));
    return r;
  endfunction

  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ra(input logic [3:0] o);
    return BASE + 32'h400 + {26'h0, o, 2'b00};
  endfunction

  task automatic wr(input logic [3:0] o, input logic [7:0] d);
    apb(1'b1, ra(o), d);
  endtask

  task automatic rdchk(input logic [3:0] o, input logic [7:0] e);
    apb(1'b0, ra(o), 8'h00);
    chk(rd, {24'h0, e});
    chk({31'h0, se}, 32'h0);
  endtask

  task automatic do_reset(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] o);
    @(posedge clock);
    rst_n <= 1'b0;
    pb0 <= b0;
    pb1 <= b1;
    opt <= o;
    ep0 <= b0;
    ep1 <= b1;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask

  // ************************************************
  // Scenarios
  // ************************************************
  // State right after reset, both banks
  task automatic t_reset;
    chk({31'h0, bank_select_bit}, 32'h0);
    rdchk(IDX_CONFIG, 8'h00);
    rdchk(IDX_PROT, pb0);
    rdchk(IDX_SECURITY, opt);
    chk({30'h0, protection_open_bit}, {30'h0, pb1[7], pb0[7]});
    wr(IDX_CONFIG, 8'h01);
    rdchk(IDX_PROT, pb1);
    wr(IDX_CONFIG, 8'h00);
  endtask

  // Access kinds, banking and window edges
  task automatic t_regs;
    wr(IDX_CLKDIV, 8'h25);
    rdchk(IDX_CLKDIV, 8'hA5);
    wr(IDX_CLKDIV, 8'h11);
    rdchk(IDX_CLKDIV, 8'hA5);
    wr(IDX_SECURITY, ~opt);
    rdchk(IDX_SECURITY, opt);
    wr(IDX_CONFIG, 8'hFF);
    rdchk(IDX_CONFIG, 8'hE1);
    chk({31'h0, bank_select_bit}, 32'h1);
    for (int i = 2; i < 16; i++) begin
      if (i < 3 || i > 6) begin
        wr(i[3:0], 8'hFF);
        rdchk(i[3:0], 8'h00);
      end
    end
    for (int o = 5; o < 7; o++) begin
      wr(o[3:0], 8'h50 + o[7:0]);
      wr(IDX_CONFIG, 8'h00);
      wr(o[3:0], 8'hA0 + o[7:0]);
      rdchk(o[3:0], 8'hA0 + o[7:0]);
      wr(IDX_CONFIG, 8'h01);
      rdchk(o[3:0], 8'h50 + o[7:0]);
    end
    apb(1'b1, BASE + 32'h440, 8'h77);
    apb(1'b0, BASE + 32'h440, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, 32'h400, 8'h00);
    chk(rd, 32'h0);
    wr(IDX_CONFIG, 8'h00);
  endtask

  // Fixed and paged windows with protection
  task automatic t_map;
    for (int i = 0; i < 9; i++) begin
      host.cycle(8'h38, FX[i], 1'b1, m);
      chk_map(m, ref_map(8'h38, FX[i], 1'b1));
    end
    for (int p = 8'h37; p <= 8'h40; p++) begin
      for (int j = 0; j < 9; j++) begin
        host.cycle(p[7:0], PA[j], j != 0, m);
        chk_map(m, ref_map(p[7:0], PA[j], j != 0));
      end
    end
  endtask

  // Protection register write, bank 0
  task automatic t_prot(input logic [7:0] wv, input logic [7:0] ev);
    wr(IDX_CONFIG, 8'h00);
    wr(IDX_PROT, wv);
    rdchk(IDX_PROT, ev);
    ep0 = ev;
    chk({31'h0, protection_open_bit[0]}, {31'h0, ev[7]});
  endtask

  // ************************************************
  // Main sequence and watchdog
  // ************************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pb0 = 8'h00;
    pb1 = 8'h00;
    opt = 8'h00;
    err_count = 0;
    checks_done = 0;
    do_reset(8'h80, 8'h00, 8'hA6);
    t_reset;
    t_map;
    t_regs;
    t_prot(8'h00, 8'h00);
    t_map;
    do_reset(8'hA4, 8'h9B, 8'h5D);
    t_reset;
    t_map;
    t_prot(8'hBC, 8'hBC);
    t_map;
    t_prot(8'h91, 8'h91);
    t_map;
    t_prot(8'hFF, 8'h91);
    conclude;
  end

  // Cut a hang short
  initial begin
    #200000;
    err_count++;
    conclude;
  end
endmodule

`default_nettype wire
